// [i2cbc_cfg.svh]
`ifndef I2CBC_CFG_SVH
`define I2CBC_CFG_SVH

// Register offsets on the register port
`define I2CBC_ADDR_CTL1 2'h0
`define I2CBC_ADDR_CTL2 2'h1
`define I2CBC_ADDR_DATA 2'h2
`define I2CBC_ADDR_OWN 2'h3

// Reset values
`define I2CBC_CTL1_RST 8'h00
`define I2CBC_OWN_RST 8'h00
`define I2CBC_DATA_RST 8'h00

// Soft reset field sequence
`define I2CBC_SOFT_RESET_FIELD_ARM 2'h2
`define I2CBC_SOFT_RESET_FIELD_FIRE 2'h1

// Serial clock high and low periods in core clock cycles
`define I2CBC_THIGH_0 9'h009
`define I2CBC_TLOW_0 9'h00C
`define I2CBC_THIGH_1 9'h00B
`define I2CBC_TLOW_1 9'h00E
`define I2CBC_THIGH_2 9'h00F
`define I2CBC_TLOW_2 9'h012
`define I2CBC_THIGH_3 9'h017
`define I2CBC_TLOW_3 9'h01A
`define I2CBC_THIGH_4 9'h027
`define I2CBC_TLOW_4 9'h02A
`define I2CBC_THIGH_5 9'h047
`define I2CBC_TLOW_5 9'h04A
`define I2CBC_THIGH_6 9'h087
`define I2CBC_TLOW_6 9'h08A
`define I2CBC_THIGH_7 9'h107
`define I2CBC_TLOW_7 9'h10A

// Data bits per word when the bit count field is zero
`define I2CBC_FULL_WORD 4'h8

`endif

// [i2cbc_pkg.sv]
`default_nettype none

package i2cbc_pkg;

   typedef struct packed {
      logic [2:0] bit_count_select;
      logic ack_mode;
      logic address_detect_disable;
      logic [2:0] clock_rate_select;
   } i2cbc_ctl1_t;

   typedef struct packed {
      logic master_select;
      logic transmit_select;
      logic bus_busy_cmd;
      logic service_pending;
      logic interface_mode_select;
      logic unused;
      logic [1:0] soft_reset_field;
   } i2cbc_ctl2_t;

   typedef struct packed {
      logic master_select;
      logic transmit_select;
      logic bus_busy_flag;
      logic service_pending;
      logic arbitration_lost_flag;
      logic addressed_flag;
      logic general_call_flag;
      logic last_rx_bit;
   } i2cbc_status_t;

   typedef struct packed {
      logic [6:0] own_slave_address;
      logic free_format_select;
   } i2cbc_own_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } i2cbc_lines_t;

   typedef enum logic [2:0] {
      MS_IDLE,
      MS_START,
      MS_LOW,
      MS_REL,
      MS_HIGH,
      MS_STOP_LOW,
      MS_STOP_REL,
      MS_STOP_SETUP
   } i2cbc_mstate_t;

endpackage

`default_nettype wire

// [i2cbc_sync.sv]
`default_nettype none

module i2cbc_sync (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Asynchronous level in, synchronised level out
   input wire logic async_in,
   output logic sync_out
);

   logic meta_reg;
   logic meta_next;
   logic sync_next;

   // Idle bus lines are high, so both stages reset high
   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         meta_reg <= 1'b1;
         sync_out <= 1'b1;
      end else begin
         meta_reg <= meta_next;
         sync_out <= sync_next;
      end
   end

endmodule

`default_nettype wire

// [i2cbc_top.sv]
`default_nettype none
`include "i2cbc_cfg.svh"

// Behaviour
// - master clock high/low periods from rate select
// - start hold and stop setup one high
// - slave releases clock one low period later
// - bus clock low during high restarts low
// - wait for real high before counting high
// - master bit cleared on stop or lost
// - slave address match copies direction bit
// - master ack copies inverted direction bit
// - transmit bit cleared on stop or lost
// - detect disable blocks matching and slave transmit update
// - free format never changes transmit bit
// - start command sends start and address
// - stop command begins stop sequence
// - stop waits for clock line release
// - bus busy follows start and stop
// - master interrupt after programmed clock count
// - slave interrupt after match, call, words
// - interrupt clears pending, clock held low
// - data write or one sets pending
// - mode bit zero blocks other control 2 bit writes
// - soft reset sequence 10 then 01
// - bit count sets word, start clears
// - compare data on clock rise, flag lost
module i2cbc_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Clock line, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   // Data line, open drain
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Interrupt request
   output logic serial_irq
);

   i2cbc_pkg::i2cbc_lines_t line_s;
   i2cbc_pkg::i2cbc_lines_t line_d_reg;
   i2cbc_pkg::i2cbc_lines_t line_d_next;

   i2cbc_sync u_scl_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .async_in(scl_in),
      .sync_out(line_s.scl)
   );

   i2cbc_sync u_sda_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .async_in(sda_in),
      .sync_out(line_s.sda)
   );

   // Control and status state
   i2cbc_pkg::i2cbc_ctl1_t ctl1_reg, ctl1_next;
   i2cbc_pkg::i2cbc_own_t own_reg, own_next;
   i2cbc_pkg::i2cbc_ctl2_t w2;
   logic mst_reg, mst_next, trx_reg, trx_next, pin_reg, pin_next;
   logic mode_reg, mode_next, armed_reg, armed_next, bb_reg, bb_next;
   logic al_reg, al_next, aas_reg, aas_next, ad0_reg, ad0_next, lrb_reg, lrb_next;
   logic [7:0] shift_reg, shift_next;
   logic out_bit_reg, out_bit_next, first_reg, first_next, active_reg, active_next;
   logic stop_req_reg, stop_req_next, irq_next;
   logic [3:0] clk_cnt_reg, clk_cnt_next;
   logic [8:0] rel_cnt_reg, rel_cnt_next;
   // Master clock generator state
   i2cbc_pkg::i2cbc_mstate_t mstate_reg, mstate_next;
   logic [8:0] mcnt_reg, mcnt_next;
   // Pin and read data outputs
   logic scl_oe_next, sda_oe_next;
   logic [7:0] rdata_next;

   logic [8:0] thigh, tlow;
   logic [3:0] nbits, total;
   logic wr_ctl2, start_cmd, stop_cmd, soft_reset_field_fire;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic m_scl_low, m_sda_low, s_scl_low, addr_ok, gcall, match;

   always_comb begin
      unique case (ctl1_reg.clock_rate_select)
         3'h0: begin thigh = `I2CBC_THIGH_0; tlow = `I2CBC_TLOW_0; end
         3'h1: begin thigh = `I2CBC_THIGH_1; tlow = `I2CBC_TLOW_1; end
         3'h2: begin thigh = `I2CBC_THIGH_2; tlow = `I2CBC_TLOW_2; end
         3'h3: begin thigh = `I2CBC_THIGH_3; tlow = `I2CBC_TLOW_3; end
         3'h4: begin thigh = `I2CBC_THIGH_4; tlow = `I2CBC_TLOW_4; end
         3'h5: begin thigh = `I2CBC_THIGH_5; tlow = `I2CBC_TLOW_5; end
         3'h6: begin thigh = `I2CBC_THIGH_6; tlow = `I2CBC_TLOW_6; end
         3'h7: begin thigh = `I2CBC_THIGH_7; tlow = `I2CBC_TLOW_7; end
      endcase
   end

   // Line edges; a single synchronised high or low cycle of the external clock is seen
   assign line_d_next = line_s;
   assign scl_rise = mode_reg & line_s.scl & ~line_d_reg.scl;
   assign scl_fall = mode_reg & ~line_s.scl & line_d_reg.scl;
   assign start_det = mode_reg & line_s.scl & line_d_reg.scl & line_d_reg.sda & ~line_s.sda;
   assign stop_det = mode_reg & line_s.scl & line_d_reg.scl & ~line_d_reg.sda & line_s.sda;

   assign nbits = (ctl1_reg.bit_count_select == 3'h0) ? `I2CBC_FULL_WORD :
                  {1'b0, ctl1_reg.bit_count_select};
   assign total = nbits + {3'h0, ctl1_reg.ack_mode};

   assign w2 = reg_wdata;
   assign wr_ctl2 = reg_wr & (reg_addr == `I2CBC_ADDR_CTL2);
   assign start_cmd = wr_ctl2 & mode_reg & w2.master_select & w2.transmit_select &
                      w2.bus_busy_cmd & w2.service_pending & ~bb_reg;
   assign stop_cmd = wr_ctl2 & mode_reg & w2.master_select & w2.transmit_select &
                     ~w2.bus_busy_cmd & w2.service_pending & bb_reg;
   assign soft_reset_field_fire = wr_ctl2 & mode_reg & armed_reg &
                       (w2.soft_reset_field == `I2CBC_SOFT_RESET_FIELD_FIRE);

   // Address phase decode at the end of the first eight data bits
   assign addr_ok = first_reg & ~mst_reg & ~own_reg.free_format_select &
                    ~ctl1_reg.address_detect_disable;
   assign match = addr_ok & (shift_reg[7:1] == own_reg.own_slave_address);
   assign gcall = addr_ok & (shift_reg == 8'h00);

   // Master clock generator
   always_comb begin
      mstate_next = mstate_reg;
      mcnt_next = mcnt_reg + 9'h001;
      unique case (mstate_reg)
         i2cbc_pkg::MS_IDLE: begin
            mcnt_next = 9'h000;
            if (start_cmd) begin
               mstate_next = i2cbc_pkg::MS_START;
            end
         end
         i2cbc_pkg::MS_START: begin
            if (mcnt_next >= thigh) begin
               mstate_next = i2cbc_pkg::MS_LOW;
               mcnt_next = 9'h000;
            end
         end
         i2cbc_pkg::MS_LOW: begin
            if (stop_req_reg & pin_reg) begin
               mstate_next = i2cbc_pkg::MS_STOP_LOW;
               mcnt_next = 9'h000;
            end else if (!pin_reg) begin
               mcnt_next = 9'h000;
            end else if (mcnt_next >= tlow) begin
               mstate_next = i2cbc_pkg::MS_REL;
               mcnt_next = 9'h000;
            end
         end
         i2cbc_pkg::MS_REL: begin
            mcnt_next = 9'h000;
            if (line_s.scl) begin
               mstate_next = i2cbc_pkg::MS_HIGH;
            end
         end
         i2cbc_pkg::MS_HIGH: begin
            if (!line_s.scl) begin
               mstate_next = i2cbc_pkg::MS_LOW;
               mcnt_next = 9'h000;
            end else if (mcnt_next >= thigh) begin
               mstate_next = i2cbc_pkg::MS_LOW;
               mcnt_next = 9'h000;
            end
         end
         i2cbc_pkg::MS_STOP_LOW: begin
            if (mcnt_next >= tlow) begin
               mstate_next = i2cbc_pkg::MS_STOP_REL;
               mcnt_next = 9'h000;
            end
         end
         i2cbc_pkg::MS_STOP_REL: begin
            mcnt_next = 9'h000;
            if (line_s.scl) begin
               mstate_next = i2cbc_pkg::MS_STOP_SETUP;
            end
         end
         i2cbc_pkg::MS_STOP_SETUP: begin
            if (mcnt_next >= thigh) begin
               mstate_next = i2cbc_pkg::MS_IDLE;
               mcnt_next = 9'h000;
            end
         end
      endcase
      // A lost arbitration drops mastership; stop is let finish
      if (!mst_reg && (mstate_reg inside {i2cbc_pkg::MS_START, i2cbc_pkg::MS_LOW,
                       i2cbc_pkg::MS_REL, i2cbc_pkg::MS_HIGH})) begin
         mstate_next = i2cbc_pkg::MS_IDLE;
      end
      if (!mode_reg || soft_reset_field_fire) begin
         mstate_next = i2cbc_pkg::MS_IDLE;
         mcnt_next = 9'h000;
      end
   end

   assign m_scl_low = (mstate_reg == i2cbc_pkg::MS_LOW) | (mstate_reg == i2cbc_pkg::MS_STOP_LOW);
   assign m_sda_low = mstate_reg inside {i2cbc_pkg::MS_START, i2cbc_pkg::MS_STOP_LOW,
                      i2cbc_pkg::MS_STOP_REL, i2cbc_pkg::MS_STOP_SETUP};
   assign s_scl_low = ~mst_reg & active_reg & (~pin_reg | (rel_cnt_reg != 9'h000));

   // Registers and bit engine; software writes come first so bus events win, except soft reset, which comes last and wins
   always_comb begin
      ctl1_next = ctl1_reg;
      own_next = own_reg;
      mst_next = mst_reg;
      trx_next = trx_reg;
      pin_next = pin_reg;
      mode_next = mode_reg;
      armed_next = armed_reg;
      bb_next = bb_reg;
      al_next = al_reg;
      aas_next = aas_reg;
      ad0_next = ad0_reg;
      lrb_next = lrb_reg;
      shift_next = shift_reg;
      out_bit_next = out_bit_reg;
      first_next = first_reg;
      active_next = active_reg;
      stop_req_next = stop_req_reg;
      clk_cnt_next = clk_cnt_reg;
      irq_next = 1'b0;
      rel_cnt_next = (rel_cnt_reg != 9'h000) ? rel_cnt_reg - 9'h001 : 9'h000;

      if (reg_wr && reg_addr == `I2CBC_ADDR_CTL1) begin
         ctl1_next = reg_wdata;
      end
      if (reg_wr && reg_addr == `I2CBC_ADDR_OWN) begin
         own_next = reg_wdata;
      end
      if (wr_ctl2) begin
         mode_next = w2.interface_mode_select;
      end
      if (wr_ctl2 && mode_reg) begin
         mst_next = w2.master_select;
         trx_next = w2.transmit_select;
         al_next = 1'b0;
         armed_next = (w2.soft_reset_field == `I2CBC_SOFT_RESET_FIELD_ARM);
         if (w2.service_pending) begin
            pin_next = 1'b1;
         end
         if (stop_cmd) begin
            stop_req_next = 1'b1;
         end
      end
      if (reg_wr && reg_addr == `I2CBC_ADDR_DATA) begin
         shift_next = reg_wdata;
         pin_next = 1'b1;
         al_next = 1'b0;
         aas_next = 1'b0;
         if (trx_reg && clk_cnt_reg == 4'h0 && !first_reg) begin
            out_bit_next = reg_wdata[7];
         end
      end
      if (reg_rd && reg_addr == `I2CBC_ADDR_DATA) begin
         al_next = 1'b0;
         aas_next = 1'b0;
      end
      if (pin_next && !pin_reg && !mst_reg) begin
         rel_cnt_next = tlow;
      end

      if (start_det) begin
         bb_next = 1'b1;
         ctl1_next.bit_count_select = 3'h0;
         clk_cnt_next = 4'h0;
         first_next = 1'b1;
         ad0_next = 1'b0;
         out_bit_next = 1'b1;
         active_next = mst_reg | own_reg.free_format_select;
      end
      if (stop_det) begin
         bb_next = 1'b0;
         mst_next = 1'b0;
         trx_next = 1'b0;
         ad0_next = 1'b0;
         active_next = 1'b0;
         first_next = 1'b0;
         stop_req_next = 1'b0;
         clk_cnt_next = 4'h0;
         out_bit_next = 1'b1;
      end

      if (scl_rise && clk_cnt_reg < total && !stop_req_reg) begin
         clk_cnt_next = clk_cnt_reg + 4'h1;
         lrb_next = line_s.sda;
         if (clk_cnt_reg < nbits) begin
            shift_next = {shift_reg[6:0], line_s.sda};
            if (mst_reg && trx_reg && out_bit_reg && !line_s.sda) begin
               al_next = 1'b1;
               mst_next = 1'b0;
               trx_next = 1'b0;
               active_next = 1'b1;
               stop_req_next = 1'b0;
            end
         end else if (first_reg && mst_reg && !line_s.sda &&
                      !own_reg.free_format_select) begin
            trx_next = ~shift_reg[0];
         end
      end

      if (scl_fall) begin
         if (clk_cnt_reg == total && total != 4'h0) begin
            clk_cnt_next = 4'h0;
            first_next = 1'b0;
            out_bit_next = 1'b1;
            if (first_reg && !mst_reg && own_reg.free_format_select) begin
               aas_next = 1'b1;
            end
            if (mst_reg || active_reg) begin
               irq_next = 1'b1;
               pin_next = 1'b0;
               rel_cnt_next = 9'h000;
            end
         end else if (clk_cnt_reg == nbits && ctl1_reg.ack_mode) begin
            if (match || gcall) begin
               active_next = 1'b1;
               aas_next = 1'b1;
               ad0_next = gcall;
            end
            if (match) begin
               trx_next = shift_reg[0];
            end
            out_bit_next = ~((mst_reg | match | gcall | active_reg) &
                             ~(match ? shift_reg[0] : trx_reg));
         end else if (clk_cnt_reg < nbits) begin
            out_bit_next = trx_reg ? shift_reg[7] : 1'b1;
         end
      end

      if (soft_reset_field_fire) begin
         ctl1_next = `I2CBC_CTL1_RST;
         own_next.own_slave_address = 7'h00;
         mst_next = 1'b0;
         trx_next = 1'b0;
         pin_next = 1'b1;
         armed_next = 1'b0;
         bb_next = 1'b0;
         al_next = 1'b0;
         aas_next = 1'b0;
         ad0_next = 1'b0;
         lrb_next = 1'b0;
         out_bit_next = 1'b1;
         first_next = 1'b0;
         active_next = 1'b0;
         stop_req_next = 1'b0;
         clk_cnt_next = 4'h0;
         rel_cnt_next = 9'h000;
         irq_next = 1'b0;
      end
   end

   // Pins and read data
   always_comb begin
      scl_oe_next = mode_reg & (m_scl_low | s_scl_low);
      sda_oe_next = mode_reg & (m_sda_low | ~out_bit_reg);
      rdata_next = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            `I2CBC_ADDR_CTL1: rdata_next = ctl1_reg;
            `I2CBC_ADDR_CTL2: rdata_next = {mst_reg, trx_reg, bb_reg, pin_reg,
                                            al_reg, aas_reg, ad0_reg, lrb_reg};
            `I2CBC_ADDR_DATA: rdata_next = shift_reg;
            `I2CBC_ADDR_OWN: rdata_next = own_reg;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         line_d_reg <= 2'h3;
         mstate_reg <= i2cbc_pkg::MS_IDLE;
         mcnt_reg <= 9'h000;
         ctl1_reg <= `I2CBC_CTL1_RST;
         own_reg <= `I2CBC_OWN_RST;
         mst_reg <= 1'b0;
         trx_reg <= 1'b0;
         pin_reg <= 1'b1;
         mode_reg <= 1'b0;
         armed_reg <= 1'b0;
         bb_reg <= 1'b0;
         al_reg <= 1'b0;
         aas_reg <= 1'b0;
         ad0_reg <= 1'b0;
         lrb_reg <= 1'b0;
         shift_reg <= `I2CBC_DATA_RST;
         out_bit_reg <= 1'b1;
         first_reg <= 1'b0;
         active_reg <= 1'b0;
         stop_req_reg <= 1'b0;
         clk_cnt_reg <= 4'h0;
         rel_cnt_reg <= 9'h000;
         serial_irq <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         reg_rdata <= 8'h00;
      end else begin
         line_d_reg <= line_d_next;
         mstate_reg <= mstate_next;
         mcnt_reg <= mcnt_next;
         ctl1_reg <= ctl1_next;
         own_reg <= own_next;
         mst_reg <= mst_next;
         trx_reg <= trx_next;
         pin_reg <= pin_next;
         mode_reg <= mode_next;
         armed_reg <= armed_next;
         bb_reg <= bb_next;
         al_reg <= al_next;
         aas_reg <= aas_next;
         ad0_reg <= ad0_next;
         lrb_reg <= lrb_next;
         shift_reg <= shift_next;
         out_bit_reg <= out_bit_next;
         first_reg <= first_next;
         active_reg <= active_next;
         stop_req_reg <= stop_req_next;
         clk_cnt_reg <= clk_cnt_next;
         rel_cnt_reg <= rel_cnt_next;
         serial_irq <= irq_next;
         scl_oe <= scl_oe_next;
         sda_oe <= sda_oe_next;
         // Open drain: only ever drives low
         scl_out <= 1'b0;
         sda_out <= 1'b0;
         reg_rdata <= rdata_next;
      end
   end

endmodule

`default_nettype wire

// [i2cbc_chk.sv]
`default_nettype none

module i2cbc_chk (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Register port
   input wire logic [1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Bus lines
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Interrupt
   input wire logic serial_irq
);
   logic [9:0] hi_cnt_reg;
   logic [9:0] hi_cnt_next;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   // Cycles since the device last let go of the clock line, saturating
   always_comb begin
      hi_cnt_next = hi_cnt_reg;
      if (scl_oe) begin
         hi_cnt_next = 10'h000;
      end else if (hi_cnt_reg != 10'h3FF) begin
         hi_cnt_next = hi_cnt_reg + 10'h001;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         hi_cnt_reg <= 10'h000;
      end else begin
         hi_cnt_reg <= hi_cnt_next;
      end
   end

   sequence s_held;
      scl_oe [*8];
   endsequence

   sequence s_free;
      !scl_oe [*8];
   endsequence

   AST_IRQ_PULSE: assert property (serial_irq |=> !serial_irq)
      else $error("irq pulse longer than one cycle");
   AST_IRQ_HOLD: assert property (serial_irq |=> s_held)
      else $error("clock line not held after irq");
   AST_WR_HOLD: assert property (reg_wr && reg_addr == 2'h2 && scl_oe |=> s_held)
      else $error("clock line released too soon after data write");
   AST_LOW_MIN: assert property ($rose(scl_oe) |-> s_held)
      else $error("clock low period too short");
   AST_HIGH_MIN: assert property ($fell(scl_oe) |-> s_free)
      else $error("clock high period too short");
   AST_START_HOLD: assert property ($rose(sda_oe) && !scl_oe && scl_in |=> s_free)
      else $error("start hold too short");
   AST_STOP_SETUP: assert property ($fell(sda_oe) && !scl_oe && sda_in |-> hi_cnt_reg >= 10'h009)
      else $error("stop setup too short");
   AST_WAIT_HIGH: assert property ($fell(scl_oe) ##1 !scl_in [*8] |=> !scl_oe)
      else $error("clock pulled again before the line went high");
endmodule

`default_nettype wire

// [i2cbc_slave_model.sv]
`default_nettype none

module i2cbc_slave_model (
   // Clock
   input wire logic clk_sys,
   // Wire levels
   input wire logic scl,
   input wire logic sda,
   // Extra low time after each clock fall: zero, or five and more
   input wire logic [7:0] stretch,
   // Pull-downs
   output logic scl_oe,
   output logic sda_oe
);
   timeunit 1ns;
   timeprecision 1ns;

   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   logic [3:0] bits = 4'h0;
   logic [7:0] hold = 8'h00;
   logic ack = 1'b0;

   assign scl_oe = hold != 8'h00;
   assign sda_oe = ack;

   always @(posedge clk_sys) begin
      scl_q <= scl;
      sda_q <= sda;
      if (hold != 8'h00) hold <= hold - 8'h01;
      if (scl && scl_q && sda != sda_q) begin
         bits <= 4'h0;
      end else if (!scl_q && scl) begin
         bits <= bits + 4'h1;
      end else if (scl_q && !scl) begin
         // Acknowledge after the eighth bit of each nine-clock frame, whoever sends it
         ack <= bits == 4'h8;
         if (bits == 4'h9) bits <= 4'h0;
         hold <= stretch;
      end
   end
endmodule

`default_nettype wire

// [tb_i2c_serial_bus_control.sv]
`default_nettype none

module tb_i2c_serial_bus_control;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic scl_oe, scl_out, sda_oe, sda_out, serial_irq, m_scl_oe, m_sda_oe;
   logic [7:0] stretch = 8'h00;
   logic scl_q = 1'b1;
   logic [8:0] shift = 9'h000;
   int num_errors = 0;
   int n_checks = 0;
   int rises = 0;
   int lo_run = 0;
   int hi_run = 0;
   int last_lo = 0;
   int last_hi = 0;
   // Both lines are pulled up when nobody drives them
   wire logic scl = (scl_oe ? scl_out : 1'b1) & !m_scl_oe;
   wire logic sda = (sda_oe ? sda_out : 1'b1) & !m_sda_oe;

   i2cbc_top i2cbc_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .serial_irq(serial_irq));
   i2cbc_slave_model i2cbc_slave_model_i (.clk_sys(clk_sys), .scl(scl), .sda(sda),
      .stretch(stretch), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

   initial begin
      forever #10 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      scl_q <= scl;
      if (scl && !scl_q) rises <= rises + 1;
      if (scl && !scl_q) shift <= {shift[7:0], sda};
      lo_run <= scl_oe ? lo_run + 1 : 0;
      hi_run <= scl_oe ? 0 : hi_run + 1;
      if (!scl_oe && lo_run != 0) last_lo <= lo_run;
      if (scl_oe && hi_run != 0) last_hi <= hi_run;
   end

   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic rchk(input logic [1:0] a, input logic [7:0] e, input string nm);
      logic [7:0] d;
      rd(a, d);
      chk(nm, {8'h00, d}, {8'h00, e});
   endtask

   task automatic wait_irq;
      int i;
      i = 0;
      while (serial_irq !== 1'b1 && i < 9000) begin
         @(posedge clk_sys);
         #1;
         i++;
      end
      chk("irq", {15'h0, serial_irq}, 16'h0001);
   endtask

   task automatic wait_free;
      logic [7:0] s;
      s = 8'hFF;
      for (int i = 0; i < 100 && s[5] !== 1'b0; i++) begin
         rd(2'h1, s);
      end
   endtask

   initial begin
      int th;
      int r0;
      repeat (16) @(posedge clk_sys);
      reset_n <= 1'b1;
      rchk(2'h1, 8'h10, "status at reset");
      rchk(2'h0, 8'h00, "ctl1 at reset");
      wr(2'h1, 8'hF0);
      rchk(2'h1, 8'h10, "ctl2 in port mode");
      wr(2'h1, 8'h08);
      wr(2'h0, 8'h10);
      wr(2'h3, 8'hA0);
      wr(2'h2, 8'h6D);
      r0 = rises;
      wr(2'h1, 8'hF8);
      wait_irq();
      chk("address clocks", 16'(rises - r0), 16'h0009);
      chk("address byte", {7'h00, shift}, 16'h00DA);
      rchk(2'h1, 8'hA0, "status after address");
      // Every rate: high m = 2 << r + 7, low n = m + 3
      for (int r = 0; r < 8; r++) begin
         th = (2 << r) + 7;
         wr(2'h0, {5'h02, r[2:0]});
         r0 = rises;
         wr(2'h2, 8'h5A);
         wait_irq();
         chk("word clocks", 16'(rises - r0), 16'h0009);
         chk("low period", 16'(last_lo), 16'(th + 3));
         chk("high period", {15'h0, last_hi >= th && last_hi <= th + 5}, 16'h0001);
      end
      wr(2'h0, 8'h10);
      stretch <= 8'h28;
      r0 = rises;
      wr(2'h2, 8'h00);
      wait_irq();
      chk("stretched clocks", 16'(rises - r0), 16'h0009);
      rchk(2'h1, 8'hA0, "status after stretch");
      wr(2'h0, 8'h70);
      r0 = rises;
      wr(2'h2, 8'h00);
      wait_irq();
      chk("short word clocks", 16'(rises - r0), 16'h0004);
      wr(2'h1, 8'hD8);
      wait_free();
      rchk(2'h1, 8'h10, "status after stop");
      chk("lines after stop", {14'h0, scl, sda}, 16'h0003);
      chk("drive levels", {14'h0, scl_out, sda_out}, 16'h0000);
      wr(2'h0, 8'h17);
      rchk(2'h0, 8'h17, "ctl1 written");
      wr(2'h1, 8'h0A);
      wr(2'h1, 8'h09);
      rchk(2'h0, 8'h00, "ctl1 after soft reset");
      rchk(2'h3, 8'h00, "own after soft reset");
      rchk(2'h1, 8'h10, "status after soft reset");
      end_of_test();
   end

   // About five times the expected run length
   initial begin
      repeat (60000) @(posedge clk_sys);
      num_errors++;
      end_of_test();
   end
endmodule

bind i2cbc_top i2cbc_chk i2cbc_chk_i (.clk_sys(clk_sys), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .serial_irq(serial_irq));

`default_nettype wire
